/* File: core/irk_pkg.sv */
// Purpose: shared constants for the infrared key encoder core
// Assumes: pclk at 25 MHz stands in for the oscillator clock
// Notes:   register offsets are byte addresses on a 32-bit apb bus
package irk_pkg;
	// clock and timing figures
	localparam int          CLK_HZ        = 25000000;
	localparam int          NOKEY_MS      = 28;
	localparam int          NOKEY_CYC     = NOKEY_MS * (CLK_HZ / 1000);
	localparam logic [6:0]  DIV_4MHZ      = 7'h6f;   // divide by 111
	localparam logic [6:0]  DIV_432KHZ    = 7'h0c;   // divide by 12
	localparam logic [11:0] TMR_LAST      = 12'hfff; // 4096 periods per repetition
	localparam logic [5:0]  BIT_LAST      = 6'h3f;   // 64 subcarrier periods per bit time
	// frame schedule in subcarrier periods and bit times
	localparam logic [3:0]  SCAN_PAGE     = 4'h0;    // timer[11:8] during scan
	localparam logic [11:0] SCAN_END      = 12'h0ff;
	localparam logic [11:0] RD_LO_AT      = 12'h100;
	localparam logic [11:0] RD_HI_AT      = 12'h140;
	localparam logic [11:0] LOAD_AT       = 12'h1ff;
	localparam logic [5:0]  TX_FIRST_BIT  = 6'h08;
	localparam logic [5:0]  TX_END_BIT    = 6'h16;   // 14 bits: 8..21
	localparam int          WORD_W        = 14;
	// register map
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_ROM_ADDR  = 8'h08;
	localparam logic [7:0]  OFS_ROM_DATA  = 8'h0c;
	// control fields
	localparam int          CTRL_MULTI    = 0;
	localparam int          CTRL_OSC4M    = 1;
	localparam int          CTRL_DUTY33   = 2;
	localparam logic [2:0]  CTRL_RESET    = 3'h3;
	// code word fields
	localparam int          LO_FIELD      = 6;
	localparam int          LO_INHIBIT    = 7;
	localparam logic [2:0]  BANK_DEFAULT  = 3'h7;
	localparam logic [2:0]  NO_ROW        = 3'h7;
	// oscillator state
	typedef enum logic [0:0]
	{
		IRK_STOP = 1'b0,
		IRK_RUN  = 1'b1
	} irk_osc_e;
endpackage

/* File: core/irk_encoder.sv */
// Purpose: keypad scanner and biphase infrared transmitter with apb registers
// Assumes: sense inputs synchronous to pclk; one pclk cycle is one oscillator cycle
// Notes:   code rom image is written by software through the rom window
//
// Function
// RULE1: subcarrier divides oscillator by 111 or 12
// RULE2: subcarrier clocks timer; pulses 25 or 33 percent
// RULE3: timer 4096 periods, 64 bits of 64
// RULE4: stop oscillator, drive low after 28 ms idle
// RULE5: sense low while stopped restarts oscillator; single mode leaves sense 0 out of the wake
// RULE6: six timer bits: row high, column low
// RULE7: row per eight slots, last eight slots idle
// RULE8: low sense captures slot into key register
// RULE9: multiple keys: no send, toggle control bit
// RULE10: single mode loads bank from timer bits 5-7
// RULE11: single mode ignores sense 0 for keys
// RULE12: multi mode bank defaults to seven
// RULE13: no reliance on other bank power-on values
// RULE14: rom address is bank above key
// RULE15: two rom reads make a 16-bit word
// RULE16: low bits 0-5 are command bits
// RULE17: low bit 6 is field bit
// RULE18: low bit 7 inhibits transmission
// RULE19: high bits 0-4 are system bits
// RULE20: multi mode stores high bits 5-7 as bank
// RULE21: shift word once per bit, biphase modulated
// RULE22: infrared output active low, idles high
// RULE23: row drives active low, high otherwise
// RULE24: frame: starts, toggle, system, command, msb first
// RULE25: one sends burst in second half
`timescale 1ns/1ps
module irk_encoder
#(
	parameter int NOKEY_CYCLES = irk_pkg::NOKEY_CYC, // idle time before stop
	parameter int ROWS         = 7,
	parameter int COLS         = 8
)
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// key matrix
	input  wire logic [COLS-1:0]   key_col_sense_n,
	output logic      [ROWS-1:0]   key_row_drive_n,
	output logic      [ROWS-1:0]   key_row_drive_oe,
	// infrared driver
	output logic                   ir_pulse_out_n
);
	import irk_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations
	irk_osc_e        osc_q;             // oscillator state
	logic [2:0]      ctrl_q;            // mode, divider and duty options
	logic [6:0]      div_q;             // subcarrier divider
	logic [11:0]     timer_q;           // control timer
	logic [31:0]     idle_q;            // cycles since last single key
	logic [5:0]      key_q;             // key register
	logic [2:0]      bank_q;            // bank select flip-flops
	logic [1:0]      hits_q;            // keys seen this scan, saturating
	logic            key_ok_q;          // exactly one key this scan
	logic            toggle_q;          // control bit of next word
	logic [7:0]      lo_q;              // low code byte
	logic [7:0]      hi_q;              // high code byte
	logic [WORD_W-1:0] sh_q;            // transmit shift register
	logic            tx_q;              // frame being sent
	logic [9:0]      rom_ptr_q;         // software rom pointer, bit 0 picks byte
	logic [7:0]      rom_lo [0:511];    // low bytes per bank and key
	logic [7:0]      rom_hi [0:511];    // high bytes per bank and key
	logic [6:0]      div_last;
	logic [6:0]      duty_len;
	logic            tick;              // last oscillator cycle of a period
	logic            run;
	logic [2:0]      row;
	logic [2:0]      col;
	logic            slot_act;
	logic            sample;
	logic            col_low;
	logic            key_hit;
	logic            bank_hit;
	logic            wake_req;
	logic [8:0]      rom_idx;
	logic [5:0]      bit_no;
	logic            tx_win;
	logic            burst;
	logic            wr_en;
	logic            rd_en;
	logic            mapped;
	logic            multi;
	logic [31:0]     rd_mux;            // read data chosen by paddr
	logic [31:0]     prdata_q;          // read data register

	////////////////////////////////////////////////////////////////////////
	// helpers
	// duty portion of a subcarrier period, in oscillator cycles
	function automatic logic [6:0] duty_of(input logic [6:0] div, input logic d33);
		logic [6:0] r;
		r = d33 ? 7'(div / 7'h03) : 7'(div >> 2);
		return (r == 7'h00) ? 7'h01 : r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// timing generator
	assign run      = (osc_q == IRK_RUN);
	assign multi    = ctrl_q[CTRL_MULTI];
	assign div_last = (ctrl_q[CTRL_OSC4M] ? DIV_4MHZ : DIV_432KHZ) - 7'h01; // RULE1
	assign duty_len = duty_of(div_last + 7'h01, ctrl_q[CTRL_DUTY33]);      // RULE2
	assign tick     = run && (div_q == div_last);
	// in single mode sense 0 sits on the jumper and is always low at rest,
	// so it must not count as a wake source or the part never sleeps
	assign wake_req = !run && ((~key_col_sense_n & (multi ? {COLS{1'b1}}
	                  : {{(COLS-1){1'b1}}, 1'b0})) != '0);                 // RULE5

	// subcarrier divider, runs only with the oscillator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= 7'h00;
		else if (!run || tick)
			div_q <= 7'h00;                                                // RULE1
		else
			div_q <= div_q + 7'h01;
	end

	// control timer, one step per subcarrier period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_q <= 12'h000;
		else if (!run)
			timer_q <= 12'h000;
		else if (tick)
			timer_q <= (timer_q == TMR_LAST) ? 12'h000 : timer_q + 12'h001; // RULE3
	end

	// oscillator start and stop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			osc_q <= IRK_STOP;
		else
		begin
			case (osc_q)
				IRK_STOP:
					if (wake_req)
						osc_q <= IRK_RUN;                                  // RULE5
				IRK_RUN:
					// stop only at the end of the repetition
					if (tick && timer_q == TMR_LAST && idle_q >= NOKEY_CYCLES)
						osc_q <= IRK_STOP;                                 // RULE4
				default:
					osc_q <= IRK_STOP;
			endcase
		end
	end

	// idle time since the last single key, saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idle_q <= 32'h0000_0000;
		else if (tick && timer_q == SCAN_END && hits_q == 2'h1 && !(sample && key_hit))
			idle_q <= 32'h0000_0000;                                       // RULE4
		else if (idle_q < NOKEY_CYCLES)
			idle_q <= idle_q + 32'h0000_0001;
	end

	////////////////////////////////////////////////////////////////////////
	// key scanning
	assign slot_act = run && (timer_q[11:8] == SCAN_PAGE);
	assign row      = timer_q[7:5];                                        // RULE6
	assign col      = timer_q[4:2];                                        // RULE6
	assign sample   = slot_act && tick && (timer_q[1:0] == 2'h3);
	assign col_low  = (32'(col) < COLS) ? !key_col_sense_n[col] : 1'b0;
	assign key_hit  = col_low && (row != NO_ROW) && !(!multi && col == 3'h0); // RULE11
	assign bank_hit = col_low && !multi && (col == 3'h0);

	// row drives: one row low per eight slots, all low when stopped
	always_comb
	begin
		key_row_drive_n = {ROWS{1'b1}};                                    // RULE23
		if (!run)
			key_row_drive_n = {ROWS{1'b0}};                                // RULE4
		else if (slot_act && row != NO_ROW)
			key_row_drive_n[row] = 1'b0;                                   // RULE7
	end
	assign key_row_drive_oe = ~key_row_drive_n;

	// hit count and key register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hits_q   <= 2'h0;
			key_q    <= 6'h00;
			key_ok_q <= 1'b0;
		end
		else if (!run)
			hits_q <= 2'h0;
		else if (tick && timer_q == SCAN_END)
		begin
			// two or more keys count as no key
			key_ok_q <= (hits_q == 2'h1) && !(sample && key_hit);          // RULE9
			hits_q   <= 2'h0;
		end
		else if (sample && key_hit)
		begin
			key_q  <= timer_q[7:2];                                        // RULE8
			hits_q <= (hits_q == 2'h3) ? 2'h3 : hits_q + 2'h1;
		end
	end

	// bank select: jumper in single mode, code word in multi mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bank_q <= BANK_DEFAULT;                                        // RULE12 RULE13
		else if (sample && bank_hit)
			bank_q <= timer_q[7:5];                                        // RULE10
		else if (multi && tick && timer_q == RD_HI_AT && key_ok_q)
			bank_q <= rom_hi[rom_idx][7:5];                                // RULE20
	end

	// toggle flips on a multi-key scan
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			toggle_q <= 1'b0;
		else if (tick && timer_q == SCAN_END && (hits_q >= 2'h2 || (hits_q == 2'h1 && sample && key_hit)))
			toggle_q <= !toggle_q;                                         // RULE9
	end

	////////////////////////////////////////////////////////////////////////
	// code rom access
	assign rom_idx = {bank_q, key_q};                                      // RULE14

	// two reads per command; high read keeps the bank used for low read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lo_q <= 8'h00;
			hi_q <= 8'h00;
		end
		else if (tick && timer_q == RD_LO_AT)
			lo_q <= rom_lo[rom_idx];                                       // RULE15
		else if (tick && timer_q == RD_HI_AT)
			hi_q <= rom_hi[rom_idx];                                       // RULE15
	end

	////////////////////////////////////////////////////////////////////////
	// pulse output
	assign bit_no = timer_q[11:6];
	assign tx_win = run && tx_q && (bit_no >= TX_FIRST_BIT) && (bit_no < TX_END_BIT);
	// one: burst in second half, zero: first half
	assign burst  = tx_win && (sh_q[WORD_W-1] ? timer_q[5] : !timer_q[5]); // RULE25

	// load and shift the remote-control word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sh_q <= '0;
			tx_q <= 1'b0;
		end
		else if (!run)
			tx_q <= 1'b0;
		else if (tick && timer_q == LOAD_AT)
		begin
			// start, field, toggle, system 4..0, command 5..0
			sh_q <= {1'b1, lo_q[LO_FIELD], toggle_q, hi_q[4:0], lo_q[5:0]}; // RULE24 RULE16 RULE17 RULE19
			tx_q <= key_ok_q && !lo_q[LO_INHIBIT];                         // RULE18
		end
		else if (tick && tx_win && timer_q[5:0] == BIT_LAST)
			sh_q <= {sh_q[WORD_W-2:0], 1'b0};                              // RULE21
	end

	// modulation from the inverted subcarrier, output sinks when active
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ir_pulse_out_n <= 1'b1;
		else
			ir_pulse_out_n <= !(burst && (div_q < duty_len));              // RULE2 RULE21 RULE22
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, error on unmapped offsets
	assign pready  = 1'b1;
	assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
	                 (paddr == OFS_ROM_ADDR) || (paddr == OFS_ROM_DATA);
	assign pslverr = psel && penable && !mapped;
	assign wr_en   = psel && penable && pwrite && mapped;
	assign rd_en   = psel && penable && !pwrite;

	// control and rom pointer; data access steps the pointer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q    <= CTRL_RESET;
			rom_ptr_q <= 10'h000;
		end
		else if (wr_en && paddr == OFS_CTRL)
			ctrl_q <= pwdata[2:0];
		else if (wr_en && paddr == OFS_ROM_ADDR)
			rom_ptr_q <= pwdata[9:0];
		else if ((wr_en || rd_en) && paddr == OFS_ROM_DATA)
			rom_ptr_q <= rom_ptr_q + 10'h001;
	end

	// rom image storage, no reset on the array
	always_ff @(posedge pclk)
	begin
		if (wr_en && paddr == OFS_ROM_DATA && !rom_ptr_q[0])
			rom_lo[rom_ptr_q[9:1]] <= pwdata[7:0];
		if (wr_en && paddr == OFS_ROM_DATA && rom_ptr_q[0])
			rom_hi[rom_ptr_q[9:1]] <= pwdata[7:0];
	end

	// read mux, looked at in the setup cycle of a read
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (psel && !pwrite)
		begin
			case (paddr)
				OFS_CTRL:     rd_mux = {29'h0, ctrl_q};
				OFS_STATUS:   rd_mux = {17'h0, tx_q, key_ok_q, toggle_q, bank_q,
				                        key_q, hits_q, run};
				OFS_ROM_ADDR: rd_mux = {22'h0, rom_ptr_q};
				OFS_ROM_DATA: rd_mux = {24'h0, rom_ptr_q[0] ? rom_hi[rom_ptr_q[9:1]]
				                                            : rom_lo[rom_ptr_q[9:1]]};
				default:      rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// read data register: loaded at the end of setup so that it stands from a
	// flip-flop through the access cycle and the bus keeps zero wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_q <= rd_mux;
		else
			prdata_q <= 32'h0000_0000;
	end
	assign prdata = prdata_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_div_period: assert property (@(posedge pclk) disable iff (!presetn)
		tick |=> (div_q == 7'h00) [*1] ##1 (!run || div_q == 7'h01)) // RULE1
		else $error("subcarrier divider did not restart");
	chk_timer_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && timer_q == TMR_LAST) |=> (timer_q == 12'h000)) // RULE3
		else $error("control timer did not wrap after 4096 periods");
	chk_stop_rows: assert property (@(posedge pclk) disable iff (!presetn)
		!run |-> (key_row_drive_n == {ROWS{1'b0}})) // RULE4
		else $error("rows not low while stopped");
	chk_wake_start: assert property (@(posedge pclk) disable iff (!presetn)
		wake_req |=> run) // RULE5
		else $error("sense low did not restart oscillator");
	chk_scan_row: assert property (@(posedge pclk) disable iff (!presetn)
		(slot_act && row < 3'h7) |-> (key_row_drive_n == ~(ROWS'(1) << row))) // RULE7
		else $error("wrong row driven in scan slot");
	chk_idle_rows: assert property (@(posedge pclk) disable iff (!presetn)
		(run && !slot_act) |-> (key_row_drive_n == {ROWS{1'b1}})) // RULE23
		else $error("row driven outside scan");
	chk_key_capture: assert property (@(posedge pclk) disable iff (!presetn)
		(sample && key_hit && timer_q != SCAN_END) |=> (key_q == $past(timer_q[7:2]))) // RULE8
		else $error("key register missed slot number");
	chk_multi_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && timer_q == SCAN_END && hits_q >= 2'h2) |=> (toggle_q != $past(toggle_q) && !key_ok_q)) // RULE9
		else $error("multiple keys did not toggle");
	chk_jumper_bank: assert property (@(posedge pclk) disable iff (!presetn)
		(sample && bank_hit) |=> (bank_q == $past(timer_q[7:5]))) // RULE10
		else $error("bank not loaded from jumper row");
	chk_inhibit_off: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && timer_q == LOAD_AT && lo_q[LO_INHIBIT]) |=> !tx_q) // RULE18
		else $error("inhibited word was sent");
	chk_out_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(burst) |-> ir_pulse_out_n) // RULE22
		else $error("output active outside a burst");
	chk_pulse_duty: assert property (@(posedge pclk) disable iff (!presetn)
		!ir_pulse_out_n |-> ($past(div_q) < duty_len)) // RULE2
		else $error("modulation pulse longer than duty");
endmodule

/* File: tb/irk_matrix_model.sv */
// Purpose: key matrix, jumper and pull-ups seen by the encoder's row and column pins
// Assumes: switches are ideal; every column has a pull-up
// Notes:   jumper_row 0..6 ties column 0 to that row, 7 to ground, 8 leaves it open
`timescale 1ns/1ps
module irk_matrix_model
(
	// row side from the encoder
	input  wire logic [6:0]  key_row_drive_n,
	input  wire logic [6:0]  key_row_drive_oe,
	// switch state from the bench
	input  wire logic [55:0] key_down,
	input  wire logic [3:0]  jumper_row,
	// column side to the encoder
	output logic      [7:0]  key_col_sense_n
);
	////////////////////////////////////////////////////////////////////////////////
	// a closed switch passes a row's low onto its column, pull-ups win otherwise
	always_comb
	begin
		key_col_sense_n = 8'hff;
		// grounded jumper holds column 0 low even while the oscillator sleeps
		if (jumper_row == 4'h7)
			key_col_sense_n[0] = 1'b0;
		for (int r = 0; r < 7; r++)
		begin
			// only an enabled open drain that sinks pulls a column down
			if (key_row_drive_oe[r] && !key_row_drive_n[r])
			begin
				if (jumper_row == 4'(r))
					key_col_sense_n[0] = 1'b0;
				for (int c = 0; c < 8; c++)
				begin
					if (key_down[r * 8 + c])
						key_col_sense_n[c] = 1'b0;
				end
			end
		end
	end
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the infrared key encoder
// Assumes: divider mostly set to 12, so one repetition takes 49152 cycles
// Notes:   idle limit cut to 2000 cycles to keep the run short
`timescale 1ns/1ps
module testbench;
	import irk_pkg::*;
	localparam int P     = 12;         // pclk per subcarrier period
	localparam int BURST = P / 4 * 32; // lows in one burst half at 25 percent
	localparam int BURST33 = P / 3 * 32; // lows in one burst half at 33 percent
	logic        pclk       = 1'b0;
	logic        presetn    = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  sense_n;
	logic [6:0]  drive_n;
	logic [6:0]  drive_oe;
	logic        ir_n;
	logic [55:0] key_down   = 56'h0;   // switch state for the matrix model
	logic [3:0]  jumper_row = 4'h8;    // open jumper by default
	logic [31:0] rd;                   // last apb read data
	logic        err;                  // last apb error flag
	int          n_mismatch = 0;
	int          checked    = 0;
	int          cyc        = 0;

	irk_encoder #(.NOKEY_CYCLES(2000)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .key_col_sense_n(sense_n),
		.key_row_drive_n(drive_n), .key_row_drive_oe(drive_oe), .ir_pulse_out_n(ir_n));
	irk_matrix_model i_keys (.key_row_drive_n(drive_n), .key_row_drive_oe(drive_oe),
		.key_down(key_down), .jumper_row(jumper_row), .key_col_sense_n(sense_n));

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard; the ceiling sits just above the planned run
	always #20 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 99000)
		begin
			n_mismatch++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// verdict and comparison helpers
	task automatic close_out();
		$display("counts: checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn  <= 1'b0;
		key_down <= 56'h0;
		jumper_row <= 4'h8;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h1); // multi mode, divide by 12, 25 percent
	endtask
	// write one code word, then read it back through the window
	task automatic rom_put(input logic [2:0] bank, input logic [5:0] key,
		input logic [7:0] lo, input logic [7:0] hi);
		apb(1'b1, OFS_ROM_ADDR, {22'h0, bank, key, 1'b0});
		apb(1'b1, OFS_ROM_DATA, {24'h0, lo});
		apb(1'b1, OFS_ROM_DATA, {24'h0, hi});
		apb(1'b1, OFS_ROM_ADDR, {22'h0, bank, key, 1'b0});
		apb(1'b0, OFS_ROM_DATA, 32'h0);
		chk("rom low byte", {24'h0, lo}, rd);
		apb(1'b0, OFS_ROM_DATA, 32'h0);
		chk("rom high byte", {24'h0, hi}, rd);
	endtask
	task automatic count_low(input int n, output int lows);
		lows = 0;
		repeat (n)
		begin
			@(negedge pclk);
			if (ir_n === 1'b0)
				lows++;
		end
	endtask
	// stopped drives are all low, so any other value means the timer runs
	task automatic wait_wake();
		while (drive_n === 7'h00)
			@(negedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		chk("drives while stopped", 32'h0, {25'h0, drive_n});
		chk("ir idle level", 32'h1, {31'h0, ir_n});
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl after reset", {29'h0, CTRL_RESET}, rd);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("bank after reset", {29'h0, BANK_DEFAULT}, {29'h0, rd[11:9]});
		chk("running after reset", 32'h0, {31'h0, rd[0]});
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, OFS_CTRL, 32'h1); // multi mode, divide by 12, 25 percent
		$display("test reset values done");
	endtask
	task automatic t_single();
		logic [13:0] word;
		logic [6:0]  exp_row;
		logic [31:0] exp_h;
		int          lo_a;
		int          lo_b;
		rom_put(3'h7, 6'd10, 8'h55, 8'h6d);
		apb(1'b0, OFS_STATUS, 32'h0);
		word = {2'b11, rd[12], 5'h0d, 6'h15}; // start, field, toggle, system, command
		@(posedge pclk);
		key_down[10] <= 1'b1;
		wait_wake();
		// mid-row samples: each row spans 32 periods, last eight slots idle
		for (int r = 0; r < 8; r++)
		begin
			repeat (r == 0 ? 16 * P : 32 * P) @(negedge pclk);
			exp_row = ~(7'h1 << r);
			chk("row drive", {25'h0, exp_row}, {25'h0, drive_n});
			chk("row enable", {25'h0, ~drive_n}, {25'h0, drive_oe});
		end
		while (ir_n !== 1'b0)
			@(negedge pclk);
		count_low(32 * P - 1, lo_b);
		chk("start bit burst", 32'(BURST - 1), 32'(lo_b));
		for (int i = 12; i >= 0; i--)
		begin
			count_low(32 * P, lo_a);
			count_low(32 * P, lo_b);
			exp_h = word[i] ? {16'h0, 16'(BURST)} : {16'(BURST), 16'h0};
			chk("bit halves", exp_h, {16'(lo_a), 16'(lo_b)});
		end
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("captured key", 32'd10, {26'h0, rd[8:3]});
		chk("bank from code word", 32'h3, {29'h0, rd[11:9]});
		chk("single key valid", 32'h1, {31'h0, rd[13]});
		$display("test single key frame done");
		do_reset();
	endtask
	task automatic t_multi();
		logic tog;
		int   lows;
		apb(1'b0, OFS_STATUS, 32'h0);
		tog = rd[12];
		key_down[9]  <= 1'b1;
		key_down[10] <= 1'b1;
		wait_wake();
		count_low(23 * 64 * P, lows);
		chk("ir lows with two keys", 32'h0, 32'(lows));
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("toggle flipped", {31'h0, ~tog}, {31'h0, rd[12]});
		chk("two keys not valid", 32'h0, {31'h0, rd[13]});
		$display("test two keys done");
		do_reset();
	endtask
	task automatic t_inhibit_stop();
		int lows;
		int t;
		rom_put(3'h7, 6'd20, 8'hd5, 8'he0);
		key_down[20] <= 1'b1;
		wait_wake();
		t = cyc;
		count_low(4000, lows);
		@(posedge pclk);
		key_down[20] <= 1'b0;
		// the stop comes only at the end of the repetition
		while (drive_n !== 7'h00)
		begin
			@(negedge pclk);
			if (ir_n === 1'b0)
				lows++;
		end
		chk("ir lows for inhibited key", 32'h0, 32'(lows));
		chk("repetition length", 32'h1,
			{31'h0, (cyc - t > 4095 * P) && (cyc - t < 4097 * P)});
		chk("drives enabled when stopped", 32'h7f, {25'h0, drive_oe});
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("stopped flag", 32'h0, {31'h0, rd[0]});
		$display("test inhibit and stop done");
	endtask
	task automatic t_single_mode();
		int lows;
		apb(1'b1, OFS_CTRL, 32'h4); // single mode, divide by 12, 33 percent
		// high byte asks for bank 7, which single mode must ignore
		rom_put(3'h2, 6'd11, 8'h4b, 8'he5);
		@(posedge pclk);
		jumper_row <= 4'h2;
		repeat (20 * P) @(negedge pclk);
		chk("jumper does not wake", 32'h0, {25'h0, drive_n});
		@(posedge pclk);
		key_down[11] <= 1'b1;
		wait_wake();
		// start bit burst; the sample that found it is not counted
		while (ir_n !== 1'b0)
			@(negedge pclk);
		count_low(32 * P - 1, lows);
		chk("start burst at 33 percent", 32'(BURST33 - 1), 32'(lows));
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("bank from jumper row", 32'h2, {29'h0, rd[11:9]});
		chk("key beside jumper", 32'd11, {26'h0, rd[8:3]});
		chk("jumper not a key", 32'h1, {31'h0, rd[13]});
		$display("test single system done");
	endtask
	task automatic t_slow_osc();
		int t;
		do_reset();
		apb(1'b1, OFS_CTRL, 32'h3); // multi mode, divide by 111, 25 percent
		key_down[0] <= 1'b1;
		wait_wake();
		t = cyc;
		// row 0 stays low for 32 subcarrier periods
		while (drive_n === 7'h7e)
			@(negedge pclk);
		chk("row 0 span at divide by 111", 32'(32 * int'(DIV_4MHZ)), 32'(cyc - t));
		$display("test slow oscillator done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_single();
		t_multi();
		t_inhibit_stop();
		t_single_mode();
		t_slow_osc();
		close_out();
	end
endmodule
